// *** lane_stripe_deskew.sv ***
// four-lane block striper and sync-header de-skew with misalignment alarm
`timescale 1ns/1ns
module lane_stripe_deskew #(
  parameter int FRAME_W = 16,
  parameter logic [FRAME_W-1:0] FRAME_PATTERN = 16'hA5C3,
  parameter int FIFO_DEPTH = deskew_pkg::FIFO_DEPTH
) (
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  input wire logic [63:0] TX_WORD_IN,
  input wire logic TX_VALID_IN,
  output logic TX_READY_OUT,
  output logic [3:0] TRANSMIT_LANE_BUS_OUT,
  input wire logic [3:0] RECEIVE_LANE_BUS_IN,
  output logic [63:0] RX_WORD_OUT,
  output logic RX_VALID_OUT,
  output logic FRAME_FOUND_OUT,
  output logic RECEIVE_MISALIGN_ALARM_N_OUT,
  output logic [3:0] LANE_LOCK_OUT
);
  localparam int W = deskew_pkg::WORD_W;
  localparam int N = deskew_pkg::LANES;
  localparam int BL = deskew_pkg::BLK_LEN;
  localparam int SL = deskew_pkg::SCR_LEN;

  typedef struct packed {
    // source side
    logic [6:0] tx_ph;
    logic [N-1:0][BL-1:0] tx_sh;
    logic [SL-1:0] tx_scr;
    // skew measurement window
    logic win;
    logic [6:0] wcnt;
    logic [N-1:0] got;
    logic [N-1:0][6:0] meas;
    logic [N-1:0][6:0] dly;
    logic [N-1:0][W-1:0] blk;
    logic p3;
    logic [W-1:0] p3blk;
    logic [6:0] p3t;
    logic [2:0] stable;
    logic aligned;
    // rebuilt output stream
    logic [N-1:0][W-1:0] ob;
    logic [2:0] ocnt;
    logic [SL-1:0] rx_ds;
    logic [W-1:0] word;
    logic valid;
    logic frame;
    logic done;
  } core_t;

  core_t r;
  core_t n;
  logic pop;
  logic fifo_valid;
  logic [W-1:0] fifo_data;
  logic [N-1:0] lk;
  logic [N-1:0] stb;
  logic [W-1:0] blk_w [N];
  logic all_lock;
  logic [SL+W-1:0] sd;
  logic [SL+W-1:0] dd;

  // data path buffer ahead of the striper; its ready reaches the port
  stream_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CLOCK_IN),
    .rst_b_in(RST_B_IN),
    .in_data_in(TX_WORD_IN),
    .in_valid_in(TX_VALID_IN),
    .in_ready_out(TX_READY_OUT),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop)
  );

  lane_if lif [N] ();
  for (genvar g = 0; g < N; g++) begin : g_lane
    lane_rx u_rx (
      .clk_in(CLOCK_IN),
      .rst_b_in(RST_B_IN),
      .bit_in(RECEIVE_LANE_BUS_IN[g]),
      .lane(lif[g].rx)
    );
    assign lk[g] = lif[g].lock;
    assign stb[g] = lif[g].blk_stb && lif[g].lock;
    assign blk_w[g] = lif[g].blk;
  end

  assign all_lock = &lk;
  assign LANE_LOCK_OUT = lk;
  // active-low alarm straight from a register
  assign RECEIVE_MISALIGN_ALARM_N_OUT = r.aligned;
  assign RX_WORD_OUT = r.word;
  assign RX_VALID_OUT = r.valid;
  assign FRAME_FOUND_OUT = r.frame;
  for (genvar t = 0; t < N; t++) begin : g_tx
    assign TRANSMIT_LANE_BUS_OUT[t] = r.tx_sh[t][BL-1];
  end

  // next-state for striper, de-skew window and output burst
  always_comb begin
    n = r;
    pop = 1'b0;
    sd = '0;
    dd = '0;
    n.valid = 1'b0;
    n.frame = 1'b0;
    n.done = 1'b0;

    n.tx_ph = (r.tx_ph == 7'(BL - 1)) ? 7'h0 : 7'(r.tx_ph + 7'h1);
    for (int k = 0; k < N; k++) begin
      n.tx_sh[k] = {r.tx_sh[k][BL-2:0], 1'b0};
    end
    // lane 3 loads first, lane 0 last
    for (int k = N - 1; k >= 0; k--) begin
      // lanes staggered by 16 bit times
      if (r.tx_ph == 7'(deskew_pkg::LANE_STEP * (N - 1 - k))) begin
        sd = deskew_pkg::scramble(fifo_valid ? fifo_data : '0, r.tx_scr, 1'b0);
        n.tx_scr = sd[SL+W-1:W];
        n.tx_sh[k] = {deskew_pkg::SYNC_HDR, sd[W-1:0]};
        pop = fifo_valid;
      end
    end

    // output burst drains lane 3 buffer first
    if (r.ocnt != 3'h0) begin
      dd = deskew_pkg::scramble(r.ob[N-1], r.rx_ds, 1'b1);
      n.rx_ds = dd[SL+W-1:W];
      n.word = dd[W-1:0];
      n.valid = r.aligned;
      // frame pattern search on rebuilt words
      n.frame = r.aligned && (dd[W-1 -: FRAME_W] == FRAME_PATTERN);
      n.ob = {r.ob[N-2:0], {W{1'b0}}};
      n.ocnt = 3'(r.ocnt - 3'h1);
    end

    if (r.win) n.wcnt = 7'(r.wcnt + 7'h1);

    // all four lane buffers read together
    if (r.win && (r.got == 4'hF)) begin
      n.done = 1'b1;
      // lane 3 word becomes the first of the burst
      n.ob = r.blk;
      n.ocnt = deskew_pkg::BURST_LEN;
      // adopt measured leads as per-lane delays
      n.dly = r.meas;
      if (r.meas == r.dly) begin
        if (r.stable != 3'(deskew_pkg::STABLE_N)) n.stable = 3'(r.stable + 3'h1);
      end else begin
        n.stable = 3'h0;
      end
      n.got = 4'h0;
      n.win = 1'b0;
      if (r.p3) begin
        n.p3 = 1'b0;
        n.win = 1'b1;
        n.got = 4'h8;
        n.blk[N-1] = r.p3blk;
        n.meas[N-1] = 7'h0;
        n.wcnt = 7'(r.wcnt - r.p3t);
      end
    end

    // lane 3 header opens the window
    if (stb[N-1]) begin
      // a header that meets a closing window starts the next one at once
      if (!r.win || (r.got == 4'hF)) begin
        n.win = 1'b1;
        n.wcnt = 7'h0;
        n.got = 4'h8;
        n.blk[N-1] = blk_w[N-1];
        n.meas[N-1] = 7'h0;
      end else begin
        n.p3 = 1'b1;
        n.p3blk = blk_w[N-1];
        n.p3t = r.wcnt;
      end
    end

    for (int k = 0; k < N - 1; k++) begin
      if (r.win && stb[k] && !r.got[k]) begin
        n.got[k] = 1'b1;
        n.blk[k] = blk_w[k];
        n.meas[k] = 7'(r.wcnt + 7'h1);
      end
    end

    // lead beyond 68 bits is a misalignment
    // 20 UI link skew fits inside that window
    if (r.win && (r.wcnt == 7'(deskew_pkg::MAX_LEAD)) && (r.got != 4'hF)) begin
      n.win = 1'b0;
      n.got = 4'h0;
      n.p3 = 1'b0;
      n.stable = 3'h0;
    end

    // any lane losing lock drops alignment
    if (!all_lock) n.stable = 3'h0;
    // alarm held until all lanes lock and skew is stable
    n.aligned = all_lock && (n.stable == 3'(deskew_pkg::STABLE_N));
  end

  // reset clears delays and asserts the alarm
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // words of 8 bytes, msb first, are built in each lane receiver

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  sequence s_hdr3;
    !TRANSMIT_LANE_BUS_OUT[3] ##1 TRANSMIT_LANE_BUS_OUT[3];
  endsequence
  sequence s_hdr0;
    !TRANSMIT_LANE_BUS_OUT[0] ##1 TRANSMIT_LANE_BUS_OUT[0];
  endsequence
  sequence s_hdr2;
    !TRANSMIT_LANE_BUS_OUT[2] ##1 TRANSMIT_LANE_BUS_OUT[2];
  endsequence
  sequence s_hdr1;
    !TRANSMIT_LANE_BUS_OUT[1] ##1 TRANSMIT_LANE_BUS_OUT[1];
  endsequence

  property p_tx_hdr3;
    r.tx_ph == 7'd0 |=> s_hdr3;
  endproperty
  a_tx_hdr3: assert property (p_tx_hdr3) else $error("lane 3 block lacks 01 header");

  property p_tx_hdr0;
    r.tx_ph == 7'd48 |=> s_hdr0;
  endproperty
  a_tx_hdr0: assert property (p_tx_hdr0) else $error("lane 0 header not 18 bits before lane 3");

  property p_wrap;
    r.tx_ph == 7'd65 |=> r.tx_ph == 7'd0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("block period is not 66");

  property p_pop_slot;
    pop |-> r.tx_ph inside {7'd0, 7'd16, 7'd32, 7'd48};
  endproperty
  a_pop_slot: assert property (p_pop_slot) else $error("word taken outside a lane slot");

  property p_alarm_lock;
    RECEIVE_MISALIGN_ALARM_N_OUT |-> $past(all_lock);
  endproperty
  a_alarm_lock: assert property (p_alarm_lock) else $error("alarm cleared without all lanes locked");

  property p_relapse;
    !all_lock |=> !RECEIVE_MISALIGN_ALARM_N_OUT;
  endproperty
  a_relapse: assert property (p_relapse) else $error("alarm not raised on lane loss");

  property p_burst;
    r.done |-> (r.ocnt != 3'd0) [*4] ##1 (r.ocnt == 3'd0);
  endproperty
  a_burst: assert property (p_burst) else $error("buffer read burst is not four words");

  property p_lead;
    r.win |-> r.wcnt <= 7'd68;
  endproperty
  a_lead: assert property (p_lead) else $error("skew window ran past 68");

  property p_tx_hdr2;
    r.tx_ph == 7'h10 |=> s_hdr2;
  endproperty
  a_tx_hdr2: assert property (p_tx_hdr2) else $error("lane 2 header not 16 bits after lane 3");

  property p_tx_hdr1;
    r.tx_ph == 7'h20 |=> s_hdr1;
  endproperty
  a_tx_hdr1: assert property (p_tx_hdr1) else $error("lane 1 header not 2 bytes after lane 2");

  property p_valid_aligned;
    RX_VALID_OUT |-> $past(RECEIVE_MISALIGN_ALARM_N_OUT);
  endproperty
  a_valid_aligned: assert property (p_valid_aligned) else $error("rebuilt word issued while misaligned");

  property p_frame_valid;
    FRAME_FOUND_OUT |-> RX_VALID_OUT;
  endproperty
  a_frame_valid: assert property (p_frame_valid) else $error("frame hit outside a rebuilt word");

  property p_dly_meas;
    r.done |-> r.dly == $past(r.meas);
  endproperty
  a_dly_meas: assert property (p_dly_meas) else $error("lane delays differ from the measured skew");

  property p_open;
    stb[N-1] && !r.win |=> r.win && (r.wcnt == 7'h0);
  endproperty
  a_open: assert property (p_open) else $error("lane 3 header did not open the skew window");

  property p_stable;
    $rose(RECEIVE_MISALIGN_ALARM_N_OUT) |-> r.stable == 3'h4;
  endproperty
  a_stable: assert property (p_stable) else $error("alarm cleared before skew was stable");

  property p_overrun;
    r.win && (r.wcnt == 7'h44) && (r.got != 4'hF) |=> !RECEIVE_MISALIGN_ALARM_N_OUT;
  endproperty
  a_overrun: assert property (p_overrun) else $error("alarm clear after a skew window overrun");

  property p_first_word;
    r.done |-> r.ob[N-1] == $past(r.blk[N-1]);
  endproperty
  a_first_word: assert property (p_first_word) else $error("lane 3 block is not first in the burst");
endmodule

// *** deskew_pkg.sv ***
// shared constants and scrambler function for the four-lane stripe and de-skew block
package deskew_pkg;
  localparam int LANES = 4;
  localparam int WORD_W = 64;
  localparam int HDR_W = 2;
  localparam int BLK_LEN = 66;
  localparam logic [1:0] SYNC_HDR = 2'h1;
  localparam int DATA_BYTES = 8;
  localparam int LANE_STEP = 16;
  localparam int BUILT_IN_LEAD = 48;
  localparam int LINK_SKEW_UI = 20;
  localparam int MAX_LEAD = BUILT_IN_LEAD + LINK_SKEW_UI;
  localparam int LOCK_GOOD = 8;
  localparam int BAD_LIMIT = 4;
  localparam int STABLE_N = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int SCR_LEN = 58;
  localparam int SCR_TAP_A = 38;
  localparam int SCR_TAP_B = 57;
  localparam logic [2:0] BURST_LEN = 3'h4;

  // self-synchronous x^58 + x^39 + 1 over one word, earliest bit in the msb
  function automatic logic [SCR_LEN+WORD_W-1:0] scramble(input logic [WORD_W-1:0] d,
                                                         input logic [SCR_LEN-1:0] s,
                                                         input logic descr);
    logic [WORD_W-1:0] o;
    logic [SCR_LEN-1:0] st;
    logic b;
    o = '0;
    st = s;
    b = 1'b0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      b = d[i] ^ st[SCR_TAP_A] ^ st[SCR_TAP_B];
      o[i] = b;
      st = {st[SCR_LEN-2:0], descr ? d[i] : b};
    end
    return {st, o};
  endfunction
endpackage

// *** lane_if.sv ***
// carrier between one lane receiver and the de-skew core
`timescale 1ns/1ns
interface lane_if;
  logic lock;
  logic blk_stb;
  logic [deskew_pkg::WORD_W-1:0] blk;
  modport rx (output lock, output blk_stb, output blk);
  modport core (input lock, input blk_stb, input blk);
endinterface

// *** stream_fifo.sv ***
// parameterised valid/ready fifo in front of the striper
`timescale 1ns/1ns
module stream_fifo #(
  parameter int WIDTH = deskew_pkg::WORD_W,
  parameter int DEPTH = deskew_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
    logic rdy;
  } fifo_t;
  fifo_t r;
  fifo_t n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid_in && r.rdy;
  assign pop = out_ready_in && (r.cnt != '0);
  assign in_ready_out = r.rdy;
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out = mem[r.rd];

  // pointer and count update; ready is a register, so it is low while in reset
  always_comb begin
    n = r;
    if (push) n.wr = AW'(r.wr + 1'b1);
    if (pop) n.rd = AW'(r.rd + 1'b1);
    n.cnt = (AW+1)'(r.cnt + push - pop);
    n.rdy = (n.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // storage write
  always_ff @(posedge clk_in) begin
    if (push) mem[r.wr] <= in_data_in;
  end
endmodule

// *** lane_rx.sv ***
// one lane receiver: pin sync, serial to word, sync header hunt and lock
`timescale 1ns/1ns
module lane_rx #(
  parameter int LOCK_GOOD = deskew_pkg::LOCK_GOOD,
  parameter int BAD_LIMIT = deskew_pkg::BAD_LIMIT
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic bit_in,
  lane_if.rx lane
);
  typedef struct packed {
    logic [1:0] sync;
    logic [deskew_pkg::BLK_LEN-1:0] sh;
    logic [6:0] ph;
    logic [3:0] good;
    logic [3:0] bad;
    logic lock;
    logic stb;
    logic [deskew_pkg::WORD_W-1:0] blk;
  } lane_t;
  lane_t r;
  lane_t n;
  logic [1:0] hdr_seen;

  assign hdr_seen = r.sh[deskew_pkg::BLK_LEN-1 -: deskew_pkg::HDR_W];
  assign lane.lock = r.lock;
  assign lane.blk_stb = r.stb;
  assign lane.blk = r.blk;

  // earliest bit shifts up to the msb; no byte framing is looked for
  always_comb begin
    n = r;
    n.stb = 1'b0;
    n.sync = {r.sync[0], bit_in};
    n.sh = {r.sh[deskew_pkg::BLK_LEN-2:0], r.sync[1]};
    n.ph = 7'(r.ph + 7'h1);
    if (r.ph == 7'(deskew_pkg::BLK_LEN - 1)) begin
      n.ph = 7'h0;
      if (hdr_seen == deskew_pkg::SYNC_HDR) begin
        n.stb = 1'b1;
        n.blk = r.sh[deskew_pkg::WORD_W-1:0];
        n.bad = 4'h0;
        if (r.good != 4'(LOCK_GOOD)) n.good = 4'(r.good + 4'h1);
        if (r.good == 4'(LOCK_GOOD - 1)) n.lock = 1'b1;
      end else begin
        n.good = 4'h0;
        // hunting: hold the phase one bit to slip the boundary
        if (!r.lock) begin
          n.ph = r.ph;
        end else begin
          n.bad = 4'(r.bad + 4'h1);
          if (r.bad == 4'(BAD_LIMIT - 1)) begin
            n.lock = 1'b0;
            n.bad = 4'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  property p_lock_on_hdr;
    @(posedge clk_in) disable iff (!rst_b_in)
      $rose(r.lock) |-> $past(hdr_seen) == deskew_pkg::SYNC_HDR;
  endproperty
  a_lock_on_hdr: assert property (p_lock_on_hdr) else $error("lane locked without a sync header");

  property p_slip;
    @(posedge clk_in) disable iff (!rst_b_in)
      (!r.lock && r.ph == 7'd65 && hdr_seen != 2'h1) |=> r.ph == 7'd65;
  endproperty
  a_slip: assert property (p_slip) else $error("hunting lane did not slip");
endmodule

// *** far_end_model.sv ***
// far-end loopback model: per-lane interconnect delay and fault injection
`timescale 1ns/1ns
module far_end_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] lane_bits_in,
  input wire logic [3:0][4:0] skew_in,
  input wire logic [3:0] corrupt_in,
  output logic [3:0] lane_bits_out
);
  logic [3:0][31:0] line_r;

  // each lane gets its own interconnect delay
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_r <= '0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        line_r[k] <= {line_r[k][30:0], lane_bits_in[k]};
      end
    end
  end

  // delayed bit, inverted on a faulty lane so its headers read 10
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      lane_bits_out[k] = line_r[k][skew_in[k]] ^ corrupt_in[k];
    end
  end
endmodule

// *** lane_stripe_deskew_tb_top.sv ***
// self-checking bench: transmit lanes looped back through the far-end model
`timescale 1ns/1ns
module lane_stripe_deskew_tb_top;
  localparam logic [15:0] PATTERN = 16'ha5c3;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [63:0] tx_word = '0;
  logic tx_valid = 1'b0;
  logic tx_ready;
  logic [3:0] tx_lanes;
  logic [3:0] rx_lanes;
  logic [63:0] rx_word;
  logic rx_valid;
  logic frame_found;
  logic alarm_n;
  logic [3:0] lane_lock;
  // lane 3 earliest, lane 0 gets the full 20 UI extra
  logic [3:0][4:0] skew = {5'h00, 5'h07, 5'h0d, 5'h14};
  logic [3:0] corrupt = 4'h0;
  int errors = 0;
  int compares = 0;
  int frames = 0;
  logic [63:0] got_q[$];

  // free-running 4 ns clock
  initial begin
    forever #2 clock = ~clock;
  end

  lane_stripe_deskew #(.FRAME_W(16), .FRAME_PATTERN(PATTERN), .FIFO_DEPTH(16)) dut (
    .CLOCK_IN(clock),
    .RST_B_IN(rst_b),
    .TX_WORD_IN(tx_word),
    .TX_VALID_IN(tx_valid),
    .TX_READY_OUT(tx_ready),
    .TRANSMIT_LANE_BUS_OUT(tx_lanes),
    .RECEIVE_LANE_BUS_IN(rx_lanes),
    .RX_WORD_OUT(rx_word),
    .RX_VALID_OUT(rx_valid),
    .FRAME_FOUND_OUT(frame_found),
    .RECEIVE_MISALIGN_ALARM_N_OUT(alarm_n),
    .LANE_LOCK_OUT(lane_lock)
  );

  far_end_model far_end (
    .clk_in(clock),
    .rst_b_in(rst_b),
    .lane_bits_in(tx_lanes),
    .skew_in(skew),
    .corrupt_in(corrupt),
    .lane_bits_out(rx_lanes)
  );

  // gather non-idle rebuilt words and frame hits
  always @(negedge clock) begin
    if (rx_valid === 1'b1 && rx_word !== '0) got_q.push_back(rx_word);
    if (frame_found === 1'b1) frames++;
  end

  function automatic logic [63:0] word_of(input int i);
    return {(i % 2 == 0) ? PATTERN : 16'h5a5a, 16'h0f0f, 32'(i + 1)};
  endfunction

  task automatic check_word(input logic [63:0] act, input logic [63:0] exp);
    compares++;
    if (act !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic check_flag(input logic [3:0] act, input logic [3:0] exp);
    compares++;
    if (act !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hold reset 12 cycles and look at the idle outputs
  task automatic test_reset();
    @(negedge clock);
    rst_b = 1'b0;
    repeat (12) @(negedge clock);
    check_flag({tx_ready, rx_valid, alarm_n, frame_found}, 4'h0);
    check_flag(lane_lock, 4'h0);
    rst_b = 1'b1;
  endtask

  // header bits 0 then 1 at each lane's load slot after release
  task automatic test_headers();
    logic [3:0] hist [72];
    int l;
    int ln;
    for (int e = 1; e < 72; e++) begin
      @(negedge clock);
      hist[e] = tx_lanes;
    end
    for (int k = 0; k < 5; k++) begin
      l = (k == 4) ? 67 : 1 + 16 * (3 - k);
      ln = (k == 4) ? 3 : k;
      // the load edge is edge l, so the header shows at falling edges l and l+1
      check_flag({2'h0, hist[l][ln], hist[l+1][ln]}, 4'h1);
    end
    check_flag({3'h0, tx_ready}, 4'h1);
  endtask

  // wait for the alarm to clear, then all lanes must be locked
  task automatic test_lock();
    int n;
    n = 0;
    while (alarm_n !== 1'b1 && n < 12000) begin
      @(negedge clock);
      n++;
    end
    check_flag(lane_lock, 4'hf);
    check_flag({3'h0, alarm_n}, 4'h1);
  endtask

  // stream 24 words into a stalling fifo, expect them back in order
  task automatic test_data();
    int i;
    int refused;
    int n;
    int f0;
    got_q.delete();
    f0 = frames;
    i = 0;
    refused = 0;
    while (i < 24) begin
      @(negedge clock);
      tx_valid = 1'b1;
      tx_word = word_of(i);
      // ready is registered: its value here is what the next rising edge sees
      if (tx_ready === 1'b1) i++;
      else refused++;
    end
    @(negedge clock);
    tx_valid = 1'b0;
    check_flag({3'h0, refused != 0}, 4'h1);
    n = 0;
    while (got_q.size() < 24 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
    check_word(64'(got_q.size()), 64'h0000_0000_0000_0018);
    for (int j = 0; j < 24 && j < got_q.size(); j++) begin
      check_word(got_q[j], word_of(j));
    end
    check_word(64'(frames - f0), 64'h0000_0000_0000_000c);
  endtask

  // break lane 1 headers, expect the alarm and lane unlock, then recover
  task automatic test_fault();
    int n;
    @(negedge clock);
    corrupt = 4'h2;
    n = 0;
    while (alarm_n !== 1'b0 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    check_flag({3'h0, alarm_n}, 4'h0);
    repeat (400) @(negedge clock);
    check_flag(lane_lock, 4'hd);
    check_flag({3'h0, alarm_n}, 4'h0);
    corrupt = 4'h0;
  endtask

  // main sequence, including a reset in mid-run
  initial begin
    test_reset();
    test_headers();
    test_lock();
    test_data();
    test_fault();
    test_lock();
    test_reset();
    test_headers();
    test_lock();
    close_out();
  end

  // watchdog against a hang
  initial begin
    #(4 * 80000);
    errors++;
    close_out();
  end
endmodule
